// >>> src/bcs_clock_sync.sv
// Board clock sync, bring-up control and channel receive status registers
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// Contract
// - Board transfers run on the forwarded 100 MHz reference clock. Here they run on i_core_clk, timed as 125 MHz.
// - Registers 0x80 to 0xF0 blocked for reads and writes until both sides lock.
// - Config register 0x0F holds byte swap bit 0 and halfword swap bit 3.
// - Datapath enable bit 3 of 0x00 starts host interface; set second.
// - Clock sync enable bit 2 of 0x24 starts mezzanine synchronisation.
// - Bit 5 of 0x24 reads one once mezzanine logic is synchronised.
// - Bit 0 of 0x03 reads one once host interface logic is synchronised.
// - Both lock flags expected within 10 ms; otherwise a fault. Only mezzanine lock is timed (fault bit 6 of 0x24).
// - Completed synchronisation is kept without repeated bring-up.
// - Mute set on a channel disables that channel's input.
// - Each channel configurable independently of the others.
// - Receive PLL locks to data; host resets it when data is absent.
// - Port status bit 0 shows carrier detected.
// - Port status bit 2 shows receive PLL configured and locked.
// - Equalisation bypass and mute per channel, writable and readable.
// - Datapath enable clear resets channels, flushes FIFOs, clears flow errors.
// - Halfword swap exchanges 16-bit halves, bits within halves unchanged.
module bcs_clock_sync #(
    parameter int NCH         = 4,
    parameter int LOCK_TIMEOUT = bcs_pkg::LOCK_TIMEOUT_CYC
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_resetn,
    input  wire bcs_pkg::bcs_bus_req_t i_bus,
    output logic [7:0]               o_rdata,
    input  wire logic                i_ref_clk,
    input  wire logic                i_host_pll_lock,
    input  wire logic [NCH-1:0]      i_carrier,
    input  wire logic [NCH-1:0]      i_rx_pll_lock,
    input  wire logic [NCH-1:0]      i_fifo_ovf,
    input  wire logic [NCH-1:0]      i_fifo_unf,
    input  wire bcs_pkg::bcs_word_t  i_dma,
    output bcs_pkg::bcs_word_t       o_dma,
    output logic                     o_chan_reset,
    output logic [NCH-1:0]           o_rx_enable,
    output logic [NCH-1:0]           o_mute,
    output logic [NCH-1:0]           o_eq_bypass,
    output logic [NCH-1:0]           o_rx_pll_reset
);
    logic                     cmd_en_r, cmd_en_nxt;
    logic                     sync_en_r, sync_en_nxt;
    logic                     byte_swap_r, byte_swap_nxt;
    logic                     halfword_swap_r, halfword_swap_nxt;
    logic                     host_clock_locked_r, host_clock_locked_nxt;
    bcs_pkg::bcs_sync_state_t state_r, state_nxt;
    logic [31:0]              cnt_r, cnt_nxt;
    logic [NCH-1:0]           mute_r, mute_nxt;
    logic [NCH-1:0]           bypass_r, bypass_nxt;
    logic [NCH-1:0]           rxrst_r, rxrst_nxt;
    logic [NCH-1:0]           ovf_r, ovf_nxt;
    logic [NCH-1:0]           unf_r, unf_nxt;
    logic [7:0]               rdata_r, rdata_nxt;
    bcs_pkg::bcs_word_t       dma_r, dma_nxt;
    logic                     chan_reset_r, chan_reset_nxt;
    logic [NCH-1:0]           rx_en_r, rx_en_nxt;
    logic [1:0]               hlock_sync_r;
    logic [NCH-1:0]           carr_s1_r, carr_s2_r, pll_s1_r, pll_s2_r;
    logic                     mon_locked;
    logic                     sync_go;
    logic                     mezz_clock_locked;
    logic                     both_locked;
    logic                     in_window;

    // Byte address of a channel register
    function automatic logic [7:0] ch_addr(input int c, input logic [7:0] ofs);
        ch_addr = 8'(bcs_pkg::CH_BASE + 8'(c) * bcs_pkg::CH_STRIDE + ofs);
    endfunction : ch_addr

    // Optional byte swap within each half, then optional half exchange
    function automatic logic [31:0] order_word(input logic [31:0] w, input logic bs,
                                               input logic hs);
        logic [31:0] t;
        t = bs ? {w[23:16], w[31:24], w[7:0], w[15:8]} : w;
        order_word = hs ? {t[15:0], t[31:16]} : t;
    endfunction : order_word

    bcs_ref_lock_mon u_mon (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_ref_clk  (i_ref_clk),
        .i_enable   (sync_go),
        .o_locked   (mon_locked)
    );

    assign sync_go           = cmd_en_r & sync_en_r;
    assign mezz_clock_locked = (state_r == bcs_pkg::BCS_LOCKED);
    assign both_locked       = mezz_clock_locked & host_clock_locked_r;
    assign in_window         = (i_bus.addr >= bcs_pkg::WIN_LO) && (i_bus.addr <= bcs_pkg::WIN_HI);

    // Control and configuration registers
    always_comb begin
        cmd_en_nxt        = cmd_en_r;
        sync_en_nxt       = sync_en_r;
        byte_swap_nxt     = byte_swap_r;
        halfword_swap_nxt = halfword_swap_r;
        mute_nxt          = mute_r;
        bypass_nxt        = bypass_r;
        rxrst_nxt         = rxrst_r;
        if (i_bus.wr) begin
            if (i_bus.addr == bcs_pkg::ADDR_CMD) begin
                cmd_en_nxt = i_bus.wdata[bcs_pkg::DP_EN_BIT];
            end
            if (i_bus.addr == bcs_pkg::ADDR_SYNC) begin
                sync_en_nxt = i_bus.wdata[bcs_pkg::SYNC_EN_BIT];
            end
            if (i_bus.addr == bcs_pkg::ADDR_CFG) begin
                byte_swap_nxt     = i_bus.wdata[bcs_pkg::BYTE_SWAP_BIT];
                halfword_swap_nxt = i_bus.wdata[bcs_pkg::HALF_SWAP_BIT];
            end
            for (int c = 0; c < NCH; c++) begin
                if (both_locked && i_bus.addr == ch_addr(c, bcs_pkg::CH_CFG_OFS)) begin
                    mute_nxt[c]   = i_bus.wdata[bcs_pkg::MUTE_BIT];
                    bypass_nxt[c] = i_bus.wdata[bcs_pkg::BYPASS_BIT];
                    rxrst_nxt[c]  = i_bus.wdata[bcs_pkg::RXRST_BIT];
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd_en_r        <= 1'b0;
            sync_en_r       <= 1'b0;
            byte_swap_r     <= 1'b0;
            halfword_swap_r <= 1'b0;
            mute_r          <= '0;
            bypass_r        <= '0;
            rxrst_r         <= '0;
        end else begin
            cmd_en_r        <= cmd_en_nxt;
            sync_en_r       <= sync_en_nxt;
            byte_swap_r     <= byte_swap_nxt;
            halfword_swap_r <= halfword_swap_nxt;
            mute_r          <= mute_nxt;
            bypass_r        <= bypass_nxt;
            rxrst_r         <= rxrst_nxt;
        end
    end

    // Pin synchronisers
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hlock_sync_r <= '0;
            carr_s1_r    <= '0;
            carr_s2_r    <= '0;
            pll_s1_r     <= '0;
            pll_s2_r     <= '0;
        end else begin
            hlock_sync_r <= {hlock_sync_r[0], i_host_pll_lock};
            carr_s1_r    <= i_carrier;
            carr_s2_r    <= carr_s1_r;
            pll_s1_r     <= i_rx_pll_lock;
            pll_s2_r     <= pll_s1_r;
        end
    end

    // Synchronisation state machine and lock flags
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            bcs_pkg::BCS_IDLE: begin
                cnt_nxt = '0;
                if (sync_go) begin
                    state_nxt = bcs_pkg::BCS_SYNC;
                end
            end
            bcs_pkg::BCS_SYNC: begin
                cnt_nxt = cnt_r + 32'h00000001;
                if (!sync_go) begin
                    state_nxt = bcs_pkg::BCS_IDLE;
                end else if (mon_locked) begin
                    state_nxt = bcs_pkg::BCS_LOCKED;
                end else if (cnt_r >= 32'(LOCK_TIMEOUT - 1)) begin
                    state_nxt = bcs_pkg::BCS_FAULT;
                end
            end
            bcs_pkg::BCS_FAULT: begin
                if (!sync_go) begin
                    state_nxt = bcs_pkg::BCS_IDLE;
                end else if (mon_locked) begin
                    state_nxt = bcs_pkg::BCS_LOCKED;
                end
            end
            bcs_pkg::BCS_LOCKED: begin
                if (!sync_go) begin
                    state_nxt = bcs_pkg::BCS_IDLE;
                end
            end
        endcase
        // Host lock is kept while datapath enabled even if the host PLL lock pin drops
        host_clock_locked_nxt = cmd_en_r & (host_clock_locked_r | hlock_sync_r[1]);
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_r             <= bcs_pkg::BCS_IDLE;
            cnt_r               <= '0;
            host_clock_locked_r <= 1'b0;
        end else begin
            state_r             <= state_nxt;
            cnt_r               <= cnt_nxt;
            host_clock_locked_r <= host_clock_locked_nxt;
        end
    end

    // Read data, channel flow flags and datapath
    always_comb begin
        rdata_nxt = '0;
        if (i_bus.rd) begin
            unique case (i_bus.addr)
                bcs_pkg::ADDR_CMD:   rdata_nxt[bcs_pkg::DP_EN_BIT] = cmd_en_r;
                bcs_pkg::ADDR_HSTAT: rdata_nxt[bcs_pkg::HLOCK_BIT] = host_clock_locked_r;
                bcs_pkg::ADDR_CFG: begin
                    rdata_nxt[bcs_pkg::BYTE_SWAP_BIT] = byte_swap_r;
                    rdata_nxt[bcs_pkg::HALF_SWAP_BIT] = halfword_swap_r;
                end
                bcs_pkg::ADDR_SYNC: begin
                    rdata_nxt[bcs_pkg::SYNC_EN_BIT]    = sync_en_r;
                    rdata_nxt[bcs_pkg::MLOCK_BIT]      = mezz_clock_locked;
                    rdata_nxt[bcs_pkg::SYNC_FAULT_BIT] = (state_r == bcs_pkg::BCS_FAULT);
                end
                default: begin
                    for (int c = 0; c < NCH; c++) begin
                        if (both_locked && i_bus.addr == ch_addr(c, bcs_pkg::CH_CFG_OFS)) begin
                            rdata_nxt[bcs_pkg::MUTE_BIT]   = mute_r[c];
                            rdata_nxt[bcs_pkg::BYPASS_BIT] = bypass_r[c];
                            rdata_nxt[bcs_pkg::RXRST_BIT]  = rxrst_r[c];
                        end
                        if (both_locked && i_bus.addr == ch_addr(c, bcs_pkg::CH_STAT_OFS)) begin
                            rdata_nxt[bcs_pkg::CARRIER_BIT]  = carr_s2_r[c];
                            rdata_nxt[bcs_pkg::PLL_LOCK_BIT] = pll_s2_r[c];
                            rdata_nxt[bcs_pkg::OVF_BIT]      = ovf_r[c];
                            rdata_nxt[bcs_pkg::UNF_BIT]      = unf_r[c];
                        end
                    end
                end
            endcase
        end
        ovf_nxt        = cmd_en_r ? (ovf_r | i_fifo_ovf) : '0;
        unf_nxt        = cmd_en_r ? (unf_r | i_fifo_unf) : '0;
        chan_reset_nxt = ~cmd_en_r;
        rx_en_nxt      = {NCH{cmd_en_r}} & ~mute_r & ~rxrst_r;
        dma_nxt.valid  = i_dma.valid & cmd_en_r;
        dma_nxt.data   = order_word(i_dma.data, byte_swap_r, halfword_swap_r);
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_r      <= bcs_pkg::REG_RST;
            ovf_r        <= '0;
            unf_r        <= '0;
            chan_reset_r <= 1'b1;
            rx_en_r      <= '0;
            dma_r        <= '0;
        end else begin
            rdata_r      <= rdata_nxt;
            ovf_r        <= ovf_nxt;
            unf_r        <= unf_nxt;
            chan_reset_r <= chan_reset_nxt;
            rx_en_r      <= rx_en_nxt;
            dma_r        <= dma_nxt;
        end
    end

    assign o_rdata        = rdata_r;
    assign o_dma          = dma_r;
    assign o_chan_reset   = chan_reset_r;
    assign o_rx_enable    = rx_en_r;
    assign o_mute         = mute_r;
    assign o_eq_bypass    = bypass_r;
    assign o_rx_pll_reset = rxrst_r;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_win_read_blocked;
        i_bus.rd && in_window && !both_locked;
    endsequence
    sequence s_data_zero;
        o_rdata == 8'h00;
    endsequence
    sequence s_hw_swap_in;
        i_dma.valid && cmd_en_r && halfword_swap_r && !byte_swap_r;
    endsequence

    win_read_block_a: assert property (s_win_read_blocked |=> s_data_zero)
        else $error("Window read returned data before lock");
    win_write_block_a: assert property ((i_bus.wr && in_window && !both_locked)
                                        |=> $stable(mute_r) && $stable(bypass_r))
        else $error("Window write took effect before lock");
    cfg_swap_write_a: assert property ((i_bus.wr && i_bus.addr == bcs_pkg::ADDR_CFG)
        |=> byte_swap_r == $past(i_bus.wdata[bcs_pkg::BYTE_SWAP_BIT])
            && halfword_swap_r == $past(i_bus.wdata[bcs_pkg::HALF_SWAP_BIT]))
        else $error("Swap controls not loaded from config write");
    lock_read_a: assert property ((i_bus.rd && i_bus.addr == bcs_pkg::ADDR_SYNC)
        |=> o_rdata[bcs_pkg::MLOCK_BIT] == $past(mezz_clock_locked))
        else $error("Mezzanine lock flag misreported");
    host_lock_read_a: assert property ((i_bus.rd && i_bus.addr == bcs_pkg::ADDR_HSTAT)
        |=> o_rdata[bcs_pkg::HLOCK_BIT] == $past(host_clock_locked_r))
        else $error("Host lock flag misreported");
    sync_timeout_a: assert property ((state_r == bcs_pkg::BCS_SYNC && sync_go && !mon_locked
        && cnt_r == 32'(LOCK_TIMEOUT - 1)) |=> state_r == bcs_pkg::BCS_FAULT)
        else $error("Missing fault after lock timeout");
    lock_kept_a: assert property ((mezz_clock_locked && sync_go && !mon_locked)
                                  |=> mezz_clock_locked)
        else $error("Lock lost without enable clear");
    lock_clear_a: assert property (!sync_go |=> !mezz_clock_locked ##1 !mezz_clock_locked)
        else $error("Mezzanine lock not cleared with enable");
    host_lock_clear_a: assert property (!cmd_en_r |=> !host_clock_locked_r)
        else $error("Host lock not cleared with datapath enable");
    mute_gate_a: assert property ((|mute_r) |=> ((o_rx_enable & $past(mute_r)) == '0))
        else $error("Muted channel input still enabled");
    idle_reset_a: assert property (!cmd_en_r |=> o_chan_reset && ovf_r == '0 && unf_r == '0)
        else $error("Channels not held in reset while datapath off");
    halfword_swap_a: assert property (s_hw_swap_in
        |=> o_dma.valid && o_dma.data == {$past(i_dma.data[15:0]), $past(i_dma.data[31:16])})
        else $error("Halfword swap ordering wrong");
endmodule : bcs_clock_sync

// >>> src/bcs_pkg.sv
// Package of constants and carrier types for the board clock sync block
package bcs_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_HSTAT  = 8'h03;
    localparam logic [7:0] ADDR_CFG    = 8'h0F;
    localparam logic [7:0] ADDR_SYNC   = 8'h24;
    localparam logic [7:0] WIN_LO      = 8'h80;
    localparam logic [7:0] WIN_HI      = 8'hF0;
    localparam logic [7:0] CH_BASE     = 8'h90;
    localparam logic [7:0] CH_STRIDE   = 8'h10;
    localparam logic [7:0] CH_CFG_OFS  = 8'h00;
    localparam logic [7:0] CH_STAT_OFS = 8'h01;
    // Field positions
    localparam int DP_EN_BIT      = 3;
    localparam int HLOCK_BIT      = 0;
    localparam int BYTE_SWAP_BIT  = 0;
    localparam int HALF_SWAP_BIT  = 3;
    localparam int SYNC_EN_BIT    = 2;
    localparam int MLOCK_BIT      = 5;
    localparam int SYNC_FAULT_BIT = 6;
    localparam int MUTE_BIT       = 0;
    localparam int BYPASS_BIT     = 1;
    localparam int RXRST_BIT      = 2;
    localparam int CARRIER_BIT    = 0;
    localparam int PLL_LOCK_BIT   = 2;
    localparam int OVF_BIT        = 3;
    localparam int UNF_BIT        = 4;
    // Values after reset
    localparam logic [7:0] REG_RST = 8'h00;
    // Timing
    localparam int LOCK_TIME_MS     = 10;
    localparam int CLK_MHZ          = 125;
    localparam int LOCK_TIMEOUT_CYC = LOCK_TIME_MS * 1000 * CLK_MHZ;
    localparam int REF_MAX_GAP_CYC  = 32;
    localparam int REF_LOCK_EDGES   = 64;

    typedef enum logic [1:0] {
        BCS_IDLE   = 2'b00,
        BCS_SYNC   = 2'b01,
        BCS_LOCKED = 2'b11,
        BCS_FAULT  = 2'b10
    } bcs_sync_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bcs_bus_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } bcs_word_t;
endpackage : bcs_pkg

// >>> src/bcs_ref_lock_mon.sv
// Reference clock presence monitor sampled by the core clock
`timescale 1ns/1ps
module bcs_ref_lock_mon #(
    parameter int MAX_GAP    = bcs_pkg::REF_MAX_GAP_CYC,
    parameter int LOCK_EDGES = bcs_pkg::REF_LOCK_EDGES
) (
    input  wire logic i_core_clk,
    input  wire logic i_resetn,
    input  wire logic i_ref_clk,
    input  wire logic i_enable,
    output logic      o_locked
);
    logic [2:0]  smp_r;
    logic [2:0]  smp_nxt;
    logic [15:0] gap_r;
    logic [15:0] gap_nxt;
    logic [15:0] edges_r;
    logic [15:0] edges_nxt;
    logic        lock_r;
    logic        lock_nxt;
    logic        rise;

    always_comb begin
        smp_nxt   = {smp_r[1:0], i_ref_clk};
        rise      = smp_r[1] & ~smp_r[2];
        gap_nxt   = gap_r;
        edges_nxt = edges_r;
        lock_nxt  = lock_r;
        if (!i_enable) begin
            gap_nxt   = '0;
            edges_nxt = '0;
            lock_nxt  = 1'b0;
        end else if (rise) begin
            gap_nxt = '0;
            if (edges_r < 16'(LOCK_EDGES)) begin
                edges_nxt = edges_r + 16'h0001;
            end
            lock_nxt = (edges_r >= 16'(LOCK_EDGES - 1));
        end else if (gap_r >= 16'(MAX_GAP)) begin
            edges_nxt = '0;
            lock_nxt  = 1'b0;
        end else begin
            gap_nxt = gap_r + 16'h0001;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            smp_r   <= '0;
            gap_r   <= '0;
            edges_r <= '0;
            lock_r  <= 1'b0;
        end else begin
            smp_r   <= smp_nxt;
            gap_r   <= gap_nxt;
            edges_r <= edges_nxt;
            lock_r  <= lock_nxt;
        end
    end

    assign o_locked = lock_r;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    mon_off_clear_a: assert property (!i_enable |=> !o_locked)
        else $error("Monitor lock not cleared when disabled");
    mon_gap_loss_a: assert property ((i_enable && !rise && gap_r >= 16'(MAX_GAP))
                                     |=> !o_locked)
        else $error("Monitor lock kept after reference clock gap");
endmodule : bcs_ref_lock_mon

// >>> test/bcs_host_model.sv
// Host side model: forwarded reference clock and host lock level
`timescale 1ns/1ps
module bcs_host_model (
    input  wire logic i_run,
    output logic      o_ref_clk,
    output logic      o_host_lock
);
    initial begin
        o_ref_clk   = 1'b0;
        o_host_lock = 1'b0;
        #3;
        forever begin
            #80;
            o_ref_clk = i_run ? ~o_ref_clk : 1'b0;
        end
    end
    always @(posedge i_run) begin
        o_host_lock = 1'b1;
    end
endmodule : bcs_host_model

// >>> test/tb_top.sv
// Testbench for the board clock sync block
`timescale 1ns/1ps
module tb_top;
    localparam int NCH = 4;
    logic                  clk, resetn, run, ref_clk, hlock, chan_reset;
    bcs_pkg::bcs_bus_req_t bus;
    bcs_pkg::bcs_word_t    dma_in, dma_out;
    logic [7:0]            rdata, v;
    logic [NCH-1:0]        carrier, rxl, ovf, unf, rx_en, mute, byp, rxrst;
    logic [31:0]           seed, d;
    logic [1:0]            cfg [NCH];
    int                    fail_count, checked;

    bcs_clock_sync #(.NCH(NCH), .LOCK_TIMEOUT(2000)) bcs_clock_sync_inst (
        .i_core_clk(clk), .i_resetn(resetn), .i_bus(bus), .o_rdata(rdata),
        .i_ref_clk(ref_clk), .i_host_pll_lock(hlock), .i_carrier(carrier),
        .i_rx_pll_lock(rxl), .i_fifo_ovf(ovf), .i_fifo_unf(unf), .i_dma(dma_in),
        .o_dma(dma_out), .o_chan_reset(chan_reset), .o_rx_enable(rx_en), .o_mute(mute),
        .o_eq_bypass(byp), .o_rx_pll_reset(rxrst));
    bcs_host_model bcs_host_model_inst (.i_run(run), .o_ref_clk(ref_clk), .o_host_lock(hlock));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Reference reordering: bytes within halves, then halves
    function automatic logic [31:0] swp(input logic [31:0] x, input logic bs, input logic hs);
        logic [31:0] t;
        t = bs ? {x[23:16], x[31:24], x[7:0], x[15:8]} : x;
        return hs ? {t[15:0], t[31:16]} : t;
    endfunction : swp

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        bus <= '{1'b1, 1'b0, a, x};
        @(posedge clk);
        bus <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        @(posedge clk);
        bus <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        bus <= '0;
        #1 x = rdata;
    endtask : rd

    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] x;
        rd(a, x);
        chk(x, exp);
    endtask : rc

    task automatic conclude();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    initial begin
        #300000;
        fail_count++;
        conclude();
    end

    initial begin
        seed = 32'h6BF64B46;
        fail_count = 0;
        checked = 0;
        run = 1'b0;
        resetn = 1'b0;
        bus = '0;
        dma_in = '0;
        carrier = '0;
        rxl = '0;
        ovf = '0;
        unf = '0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        #1 chk(chan_reset, 1'b1);
        rc(bcs_pkg::ADDR_SYNC, 8'h00);
        wr(bcs_pkg::CH_BASE, 8'h03);
        rc(bcs_pkg::CH_BASE, 8'h00);
        @(posedge clk);
        dma_in <= '{1'b1, 32'h11223344};
        @(posedge clk);
        dma_in <= '0;
        #1 chk(dma_out.valid, 1'b0);
        wr(bcs_pkg::ADDR_CMD, 8'h08);
        @(posedge clk);
        #1 chk(chan_reset, 1'b0);
        wr(bcs_pkg::ADDR_SYNC, 8'h04);
        run <= 1'b1;
        v = 8'h00;
        for (int i = 0; i < 1000 && v[5] !== 1'b1; i++) rd(bcs_pkg::ADDR_SYNC, v);
        chk(v, 8'h24);
        rc(bcs_pkg::ADDR_HSTAT, 8'h01);
        run <= 1'b0;
        repeat (100) @(posedge clk);
        rc(bcs_pkg::ADDR_SYNC, 8'h24);
        for (int c = 0; c < NCH; c++) begin
            d = rnd();
            cfg[c] = d[1:0];
            wr(8'(bcs_pkg::CH_BASE + 16 * c), {6'h00, cfg[c]});
        end
        d = rnd();
        @(posedge clk);
        carrier <= d[3:0];
        rxl <= d[7:4];
        ovf <= '1;
        unf <= '1;
        @(posedge clk);
        ovf <= '0;
        unf <= '0;
        repeat (4) @(posedge clk);
        for (int c = 0; c < NCH; c++) begin
            rc(8'(bcs_pkg::CH_BASE + 16 * c), {6'h00, cfg[c]});
            rc(8'(bcs_pkg::CH_BASE + 16 * c + 1), {5'h03, rxl[c], 1'b0, carrier[c]});
            chk(mute[c], cfg[c][0]);
            chk(byp[c], cfg[c][1]);
            chk(rx_en[c], !cfg[c][0]);
        end
        wr(bcs_pkg::CH_BASE, {5'h00, 1'b1, cfg[0]});
        @(posedge clk);
        #1 chk(rxrst, 4'h1);
        chk(rx_en[0], 1'b0);
        chk(rx_en[1], !cfg[1][0]);
        wr(bcs_pkg::CH_BASE, {6'h00, cfg[0]});
        for (int m = 0; m < 4; m++) begin
            wr(bcs_pkg::ADDR_CFG, {4'h0, m[1], 2'b00, m[0]});
            d = rnd();
            @(posedge clk);
            dma_in <= '{1'b1, d};
            @(posedge clk);
            dma_in <= '0;
            #1 chk(dma_out, {1'b1, swp(d, m[0], m[1])});
        end
        rc(bcs_pkg::ADDR_CFG, 8'h09);
        wr(bcs_pkg::ADDR_CMD, 8'h00);
        wr(bcs_pkg::ADDR_SYNC, 8'h00);
        @(posedge clk);
        #1 chk(chan_reset, 1'b1);
        rc(bcs_pkg::ADDR_SYNC, 8'h00);
        rc(bcs_pkg::ADDR_HSTAT, 8'h00);
        rc(8'(bcs_pkg::CH_BASE + 1), 8'h00);
        wr(bcs_pkg::ADDR_CMD, 8'h08);
        wr(bcs_pkg::ADDR_SYNC, 8'h04);
        repeat (2010) @(posedge clk);
        rc(bcs_pkg::ADDR_SYNC, 8'h44);
        run <= 1'b1;
        v = 8'h00;
        for (int i = 0; i < 1000 && v[5] !== 1'b1; i++) rd(bcs_pkg::ADDR_SYNC, v);
        chk(v, 8'h24);
        rc(bcs_pkg::ADDR_HSTAT, 8'h01);
        rc(8'(bcs_pkg::CH_BASE + 1), {5'h00, rxl[0], 1'b0, carrier[0]});
        conclude();
    end
endmodule : tb_top
